// File: hw/pdm_defines.svh
// constants for the clock deskew and multiplier block
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PDM_CLK_MHZ        50
`define PDM_LOCK_TIME_US   10
`define PDM_LOCK_CYC       (`PDM_LOCK_TIME_US * `PDM_CLK_MHZ)
`define PDM_GOOD_PERIODS   4'h4
`define PDM_CNT_W          10

// ------------------------------------------------------------
// reference limits, MHz, per grade and factor; period tolerance in ppm
// ------------------------------------------------------------
`define PDM_F1_MIN_MHZ     25
`define PDM_F1_MAX_G1_MHZ  180
`define PDM_F1_MAX_G2_MHZ  80
`define PDM_F2_MIN_MHZ     16
`define PDM_F2_MAX_G1_MHZ  90
`define PDM_F2_MAX_G2_MHZ  40
`define PDM_TOL_PPM        25000
`define PDM_PPM_DEN        1000000

// ------------------------------------------------------------
// speed grades
// ------------------------------------------------------------
`define PDM_GRADE_1        2'h1
`define PDM_GRADE_2        2'h2

`endif

// File: hw/pdm_pkg.sv
// types for the clock deskew and multiplier block
package pdm_pkg;

  // ------------------------------------------------------------
  // configuration fixed when the device is set up
  // ------------------------------------------------------------
  typedef struct packed {
    logic       deskew_en;
    logic       mult_en;
    logic       factor_two;
    logic [1:0] grade;
    logic [7:0] nominal_period;
  } pdm_cfg_t;

  // ------------------------------------------------------------
  // loop states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PDM_OFF,
    PDM_ACQUIRE,
    PDM_LOCKED
  } pdm_state_t;

endpackage

// File: hw/pdm_clock_deskew_loop.sv
// clock deskew loop and clock multiplier, one clock domain
// Function
// - loop aligns to rising edges of the reference; falling edges ignored.
// - generated clock feeds register clocks only, never gated or inverted.
// - generated clock stays internal, never reaches an output pin.
// - reference only from input one; while looped it drives nothing else.
// - input one may feed both functions; then input two is unavailable.
// - lock acquired within 10 us of a valid reference.
// - loop set up first; locks during configuration, usable right after.
// - on a bad reference the generated clock is not treated as valid.
// - function exists only in the two fastest speed grades.
`timescale 1ns/1ps
`include "pdm_defines.svh"

module pdm_clock_deskew_loop
  import pdm_pkg::*;
(
  // clock and reset
  input  wire logic      clock_in,
  input  wire logic      rst_in,
  // configuration
  input  wire pdm_cfg_t  cfg_in,
  // dedicated clock inputs
  input  wire logic      dedicated_clock_input_one_in,
  input  wire logic      dedicated_clock_input_two_in,
  // fabric side
  output logic           ref_to_fabric_out,
  output logic           input_two_to_fabric_out,
  output logic           input_two_avail_out,
  output logic           reg_clk_en_out,
  output logic           lock_valid_out,
  output logic           lock_fail_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic doubled(input pdm_cfg_t c);
    doubled = c.mult_en & c.factor_two;
  endfunction

  function automatic logic fast_grade(input logic [1:0] g);
    fast_grade = (g == `PDM_GRADE_1) | (g == `PDM_GRADE_2);
  endfunction

  function automatic logic freq_ok(input pdm_cfg_t c);
    logic [31:0] p;
    logic [31:0] fmin;
    logic [31:0] fmax;
    p    = {24'h0, c.nominal_period};
    fmin = doubled(c) ? `PDM_F2_MIN_MHZ : `PDM_F1_MIN_MHZ;
    if (doubled(c))
      fmax = (c.grade == `PDM_GRADE_1) ? `PDM_F2_MAX_G1_MHZ : `PDM_F2_MAX_G2_MHZ;
    else
      fmax = (c.grade == `PDM_GRADE_1) ? `PDM_F1_MAX_G1_MHZ : `PDM_F1_MAX_G2_MHZ;
    freq_ok = (p != 32'h0) && (p * fmin <= `PDM_CLK_MHZ) && (p * fmax >= `PDM_CLK_MHZ);
  endfunction

  function automatic logic period_ok(input logic [`PDM_CNT_W-1:0] meas, input logic [7:0] nom);
    logic [31:0] diff;
    diff = ({22'h0, meas} > {24'h0, nom}) ? ({22'h0, meas} - {24'h0, nom})
                                          : ({24'h0, nom} - {22'h0, meas});
    period_ok = diff * `PDM_PPM_DEN <= {24'h0, nom} * `PDM_TOL_PPM;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pdm_cfg_t                cfg_r,       cfg_nxt;
  pdm_state_t              state_r,     state_nxt;
  logic                    ref_d_r,     ref_d_nxt;
  logic [`PDM_CNT_W-1:0]   per_cnt_r,   per_cnt_nxt;
  logic [`PDM_CNT_W-1:0]   half_r,      half_nxt;
  logic [`PDM_CNT_W-1:0]   acq_cnt_r,   acq_cnt_nxt;
  logic [3:0]              good_r,      good_nxt;
  logic                    en_r,        en_nxt;
  logic                    fail_r,      fail_nxt;
  logic                    loop_used;
  logic                    rise;
  logic                    timeout;
  logic                    good_period;

  // ------------------------------------------------------------
  // routing of the dedicated inputs
  // ------------------------------------------------------------
  always_comb
  begin
    loop_used   = (cfg_r.deskew_en | cfg_r.mult_en) & fast_grade(cfg_r.grade);
    rise        = dedicated_clock_input_one_in & ~ref_d_r;
    timeout     = per_cnt_r > {1'b0, cfg_r.nominal_period, 1'b0};
    good_period = period_ok(per_cnt_r, cfg_r.nominal_period) & freq_ok(cfg_r);
  end

  assign ref_to_fabric_out       = loop_used ? 1'b0 : dedicated_clock_input_one_in;
  assign input_two_avail_out     = ~(loop_used & cfg_r.deskew_en & cfg_r.mult_en);
  assign input_two_to_fabric_out = input_two_avail_out & dedicated_clock_input_two_in;
  assign reg_clk_en_out          = en_r;
  assign lock_valid_out          = (state_r == PDM_LOCKED);
  assign lock_fail_out           = fail_r;

  // ------------------------------------------------------------
  // period measurement
  // ------------------------------------------------------------
  always_comb
  begin
    ref_d_nxt   = dedicated_clock_input_one_in;
    per_cnt_nxt = per_cnt_r;
    if (rise)
      per_cnt_nxt = {{(`PDM_CNT_W-1){1'b0}}, 1'b1};
    else if (!timeout)
      per_cnt_nxt = per_cnt_r + 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ref_d_r   <= 1'b0;
      per_cnt_r <= '0;
    end
    else
    begin
      ref_d_r   <= ref_d_nxt;
      per_cnt_r <= per_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    cfg_nxt     = cfg_r;
    state_nxt   = state_r;
    half_nxt    = half_r;
    acq_cnt_nxt = acq_cnt_r;
    good_nxt    = good_r;
    en_nxt      = 1'b0;
    fail_nxt    = fail_r;
    case (state_r)
      PDM_OFF:
      begin
        good_nxt = 4'h0;
        if (loop_used && rise)
        begin
          state_nxt   = PDM_ACQUIRE;
          acq_cnt_nxt = '0;
        end
      end
      PDM_ACQUIRE:
      begin
        if (acq_cnt_r < `PDM_LOCK_CYC)
          acq_cnt_nxt = acq_cnt_r + 1'b1;
        else
          fail_nxt = 1'b1;
        if (timeout)
          state_nxt = PDM_OFF;
        else if (rise)
        begin
          half_nxt = per_cnt_r >> 1;
          if (!good_period)
            good_nxt = 4'h0;
          else if (good_r + 4'h1 >= `PDM_GOOD_PERIODS)
          begin
            state_nxt = PDM_LOCKED;
            fail_nxt  = 1'b0;
          end
          else
            good_nxt = good_r + 4'h1;
        end
      end
      PDM_LOCKED:
      begin
        if (timeout || (rise && !good_period))
        begin
          state_nxt   = PDM_ACQUIRE;
          good_nxt    = 4'h0;
          acq_cnt_nxt = '0;
        end
        else if (rise)
        begin
          half_nxt = per_cnt_r >> 1;
          en_nxt   = 1'b1;
        end
        else if (doubled(cfg_r) && per_cnt_r == half_r)
          en_nxt = 1'b1;
      end
      default:
        state_nxt = PDM_OFF;
    endcase
    if (!loop_used)
      state_nxt = PDM_OFF;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      cfg_r     <= cfg_in;
      state_r   <= PDM_OFF;
      half_r    <= '0;
      acq_cnt_r <= '0;
      good_r    <= 4'h0;
      en_r      <= 1'b0;
      fail_r    <= 1'b0;
    end
    else
    begin
      cfg_r     <= cfg_nxt;
      state_r   <= state_nxt;
      half_r    <= half_nxt;
      acq_cnt_r <= acq_cnt_nxt;
      good_r    <= good_nxt;
      en_r      <= en_nxt;
      fail_r    <= fail_nxt;
    end
  end

endmodule

// File: dv/pdm_ref_src.sv
// reference clock source model
`timescale 1ns/1ps
module pdm_ref_src (
  // control and pin
  input  wire logic       clock_in,
  input  wire logic       run_in,
  input  wire logic [3:0] per_in,
  output logic            ref_out
);
  logic [3:0] cnt_r = 4'h0;
  logic       ref_r = 1'b0;
  assign ref_out = ref_r;
  always @(posedge clock_in)
  begin
    cnt_r <= (run_in && cnt_r + 4'h1 < per_in) ? cnt_r + 4'h1 : 4'h0;
    ref_r <= run_in && cnt_r + 4'h1 >= per_in;
  end
endmodule

// File: dv/pdm_clock_deskew_loop_properties.sv
// port checks for the clock deskew loop
`timescale 1ns/1ps
module pdm_clock_deskew_loop_properties
  import pdm_pkg::*;
(
  // watched ports
  input wire logic     clock_in,
  input wire logic     rst_in,
  input wire pdm_cfg_t cfg_in,
  input wire logic     dedicated_clock_input_one_in,
  input wire logic     dedicated_clock_input_two_in,
  input wire logic     ref_to_fabric_out,
  input wire logic     input_two_to_fabric_out,
  input wire logic     input_two_avail_out,
  input wire logic     reg_clk_en_out,
  input wire logic     lock_valid_out,
  input wire logic     lock_fail_out
);
  logic prev_r, used, rise;
  assign used = (cfg_in.deskew_en | cfg_in.mult_en) & ^cfg_in.grade;
  assign rise = dedicated_clock_input_one_in & !prev_r;
  always_ff @(posedge clock_in) prev_r <= dedicated_clock_input_one_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_rst_clr: assert property ($fell(rst_in) |-> !lock_valid_out && !reg_clk_en_out) else $error("reset");
  a_rise_pulse: assert property (lock_valid_out && rise ##1 lock_valid_out |-> reg_clk_en_out) else $error("pulse");
  a_idle_quiet: assert property (!lock_valid_out && !$past(lock_valid_out) |-> !reg_clk_en_out) else $error("idle");
  a_ref_block: assert property (used |-> !ref_to_fabric_out) else $error("ref");
  a_two_avail: assert property (input_two_avail_out == !(used && cfg_in.deskew_en && cfg_in.mult_en)) else $error("two");
  a_fail_lock: assert property (lock_fail_out |-> !lock_valid_out) else $error("fail");
  a_lock_rise: assert property ($rose(lock_valid_out) |-> $past(rise)) else $error("lock");
  a_grade_off: assert property (!used |-> !lock_valid_out) else $error("grade");
  c_lock: cover property ($rose(lock_valid_out));
  c_fail: cover property ($rose(lock_fail_out));
  c_solo: cover property (!input_two_avail_out);
endmodule
bind pdm_clock_deskew_loop pdm_clock_deskew_loop_properties i_props (.*);

// File: dv/pdm_clock_deskew_loop_test.sv
// bench for the clock deskew loop
`timescale 1ns/1ps
module pdm_clock_deskew_loop_test
  import pdm_pkg::*;
;
  logic clock_in = 1'b0, rst_in = 1'b1, run = 1'b0, dedicated_clock_input_two_in = 1'b1;
  logic dedicated_clock_input_one_in, ref_to_fabric_out, input_two_to_fabric_out, input_two_avail_out;
  logic reg_clk_en_out, lock_valid_out, lock_fail_out;
  logic [3:0] per = 4'h2;
  logic [7:0] cnt;
  pdm_cfg_t   cfg_in = '0;
  // cfg, lock, input two, blocked
  logic [15:0] rows [6] = '{16'h8817, 16'h7017, 16'hE815, 16'hD812, 16'h881B, 16'h0812};
  int error_cnt = 0, num_checks = 0;
  always #10 clock_in = !clock_in;
  pdm_ref_src i_src (.clock_in, .run_in(run), .per_in(per), .ref_out(dedicated_clock_input_one_in));
  pdm_clock_deskew_loop i_dut (.*);
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("MISMATCH %0t got %b exp %b", $time, seen, exp);
  endtask
  task automatic results;
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic start(input pdm_cfg_t c, input logic [3:0] p);
    @(negedge clock_in);
    {rst_in, run, cfg_in, per} = {2'h2, c, p};
    repeat (3) @(negedge clock_in);
    {rst_in, run} = 2'h1;
  endtask
  task automatic settle(input int n);
    cnt = 8'h00;
    repeat (n) @(negedge clock_in) cnt = cnt + {7'h00, reg_clk_en_out};
  endtask
  initial
  begin
    foreach (rows[i])
    begin
      start(rows[i][15:3], 4'h2);
      settle(20);
      check(lock_valid_out, rows[i][2]);
      check(input_two_avail_out, rows[i][1]);
      check(input_two_to_fabric_out, rows[i][1]);
      check(ref_to_fabric_out, !rows[i][0] & dedicated_clock_input_one_in);
      rst_in = 1'b1;
      settle(1);
      check(lock_valid_out, 1'b0);
      check(reg_clk_en_out, 1'b0);
    end
    dedicated_clock_input_two_in = 1'b0;
    settle(1);
    check(input_two_to_fabric_out, 1'b0);
    dedicated_clock_input_two_in = 1'b1;
    start(13'hD03, 4'h3);
    settle(30);
    settle(12);
    check(cnt == 8'h08, 1'b1);
    run = 1'b0;
    settle(12);
    check(lock_valid_out, 1'b0);
    start(rows[0][15:3], 4'h4);
    settle(540);
    check(lock_valid_out | !lock_fail_out, 1'b0);
    results;
  end
  initial
  begin
    #100000 error_cnt++;
    results;
  end
endmodule
